//--- common/trsp_pkg.sv
// Constants and types shared by the receive stream port and its non-posted hold buffer.
`default_nettype none
package trsp_pkg;
	// ----------------------------------------------------------------
	// Widths and buffer sizing
	// ----------------------------------------------------------------
	localparam int         DW_W       = 32;
	localparam int         BEAT_W     = 128;
	localparam int         HOLD_DEPTH = 64;
	localparam int         HOLD_AW    = 6;
	localparam logic [6:0] HOLD_FULL  = 7'h40;
	// ----------------------------------------------------------------
	// Header dword 0 fields
	// ----------------------------------------------------------------
	localparam int         HDR_FMT_DATA = 30;
	localparam int         HDR_TYPE_HI  = 28;
	localparam int         HDR_TYPE_LO  = 24;
	localparam int         HDR_TD       = 15;
	localparam int         HDR_EP       = 14;
	localparam logic [4:0] TYPE_MEM     = 5'h00;
	localparam logic [4:0] TYPE_MEM_LK  = 5'h01;
	localparam logic [4:0] TYPE_IO      = 5'h02;
	localparam logic [4:0] TYPE_CFG0    = 5'h04;
	localparam logic [4:0] TYPE_CFG1    = 5'h05;
	// ----------------------------------------------------------------
	// Beat slots and remainder codes (active-low encoding)
	// ----------------------------------------------------------------
	localparam logic [1:0] SLOT_FIRST   = 2'h0;
	localparam logic [1:0] SLOT_LOWER   = 2'h2;
	localparam logic [1:0] SLOT_LAST    = 2'h3;
	localparam logic [1:0] REM_FULL     = 2'h0;
	localparam logic [1:0] REM_LOW_ONLY = 2'h2;

	typedef struct packed {
		logic            poison;
		logic            np;
		logic            strip;
		logic            sof;
		logic            eof;
		logic [DW_W-1:0] dw;
	} trsp_word_t;
endpackage
`default_nettype wire

//--- common/trsp_hold_if.sv
// Carrier between the receive port and its non-posted hold buffer.
`timescale 1ns/100ps
`default_nettype none
interface trsp_hold_if;
	logic                push_valid;
	logic                push_ready;
	trsp_pkg::trsp_word_t push_word;
	logic                pop_valid;
	logic                pop_ready;
	trsp_pkg::trsp_word_t pop_word;
	logic                has_pkt;
	logic                flush;

	modport ctrl (
		output push_valid, push_word, pop_ready, flush,
		input  push_ready, pop_valid, pop_word, has_pkt
	);
	modport store (
		input  push_valid, push_word, pop_ready, flush,
		output push_ready, pop_valid, pop_word, has_pkt
	);
endinterface
`default_nettype wire

//--- rtl/trsp_np_hold.sv
// Dword buffer that parks non-posted packets while the user refuses them.
`timescale 1ns/100ps
`default_nettype none
module trsp_np_hold (
	input  wire logic   clock,
	input  wire logic   srst,
	trsp_hold_if.store  port
);
	trsp_pkg::trsp_word_t mem [trsp_pkg::HOLD_DEPTH];
	logic [6:0]           wr_q, wr_d;
	logic [6:0]           rd_q, rd_d;
	logic [6:0]           pkts_q, pkts_d;
	logic                 push_fire;
	logic                 pop_fire;

	assign port.push_ready = (7'(wr_q - rd_q) != trsp_pkg::HOLD_FULL) && !port.flush;
	assign port.pop_valid  = (wr_q != rd_q) && !port.flush;
	assign port.pop_word   = mem[rd_q[trsp_pkg::HOLD_AW-1:0]];
	assign port.has_pkt    = (pkts_q != 7'h00) && !port.flush;
	assign push_fire       = port.push_valid && port.push_ready;
	assign pop_fire        = port.pop_valid && port.pop_ready;

	always_comb begin
		wr_d   = wr_q;
		rd_d   = rd_q;
		pkts_d = pkts_q;
		if (port.flush) begin
			// A lost link drops every stored packet.
			wr_d   = 7'h00;
			rd_d   = 7'h00;
			pkts_d = 7'h00;
		end else begin
			if (push_fire) begin
				wr_d = 7'(wr_q + 7'h01);
			end
			if (pop_fire) begin
				rd_d = 7'(rd_q + 7'h01);
			end
			pkts_d = 7'(pkts_q + 7'(push_fire && port.push_word.eof) - 7'(pop_fire && port.pop_word.eof));
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			wr_q   <= 7'h00;
			rd_q   <= 7'h00;
			pkts_q <= 7'h00;
		end else begin
			wr_q   <= wr_d;
			rd_q   <= rd_d;
			pkts_q <= pkts_d;
		end
		if (push_fire) begin
			mem[wr_q[trsp_pkg::HOLD_AW-1:0]] <= port.push_word;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	a_hold_no_overrun: assert property (7'(wr_q - rd_q) <= trsp_pkg::HOLD_FULL)
		else $error("hold buffer overran");
endmodule
`default_nettype wire

//--- rtl/trsp_rx_port.sv
// Receive stream port: packs received dwords into 128-bit beats for the user.
`timescale 1ns/100ps
`default_nettype none
module trsp_rx_port (
	input  wire logic         clock,
	input  wire logic         srst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [31:0]  in_dw,
	input  wire logic         in_sof,
	input  wire logic         in_eof,
	input  wire logic         strip_digest_option,
	input  wire logic         link_up_n,
	input  wire logic         rx_ready_n,
	input  wire logic         rx_np_ok_n,
	output logic [127:0]      rx_data,
	output logic              rx_valid_n,
	output logic              rx_sof_n,
	output logic              rx_eof_n,
	output logic [1:0]        rx_rem_n,
	output logic              rx_errfwd_n,
	output logic              rx_abort_n
);
	typedef enum logic [1:0] {P_FILL, P_STRAD, P_SHOW} trsp_pack_t;

	trsp_hold_if hold ();

	trsp_np_hold u_hold (
		.clock (clock),
		.srst  (srst),
		.port  (hold.store)
	);

	// ----------------------------------------------------------------
	// Digest strip stage
	// ----------------------------------------------------------------
	trsp_pkg::trsp_word_t a_q, a_d, a_out;
	logic                 a_valid_q, a_valid_d;
	logic                 pkt_pois_q, pkt_pois_d;
	logic                 pkt_np_q, pkt_np_d;
	logic                 pkt_strip_q, pkt_strip_d;
	logic                 route_q, route_d;
	logic                 route_hold;
	logic                 a_strip_end;
	logic                 a_emit;
	logic                 a_fire;
	logic                 in_take;
	logic                 link_down;
	logic                 direct_take;

	function automatic logic trsp_is_np(input logic [31:0] h);
		logic [4:0] t;
		t = h[trsp_pkg::HDR_TYPE_HI:trsp_pkg::HDR_TYPE_LO];
		return ((t == trsp_pkg::TYPE_MEM || t == trsp_pkg::TYPE_MEM_LK) && !h[trsp_pkg::HDR_FMT_DATA])
			|| t == trsp_pkg::TYPE_IO || t == trsp_pkg::TYPE_CFG0 || t == trsp_pkg::TYPE_CFG1;
	endfunction

	assign link_down   = link_up_n;
	// One dword is held back so that a trailing digest can be dropped and its end moved forward.
	// digest kept unless stripping
	assign a_strip_end = in_valid && in_eof && a_valid_q && a_q.strip && !a_q.eof;
	assign a_emit      = a_valid_q && (a_q.eof || in_valid) && !link_down;
	// park refused non-posted
	// A non-posted packet is parked while refused or while older ones still wait, keeping their order.
	assign route_hold  = a_q.sof ? (a_q.np && (rx_np_ok_n || hold.pop_valid)) : route_q;
	assign a_fire      = a_emit && (route_hold ? hold.push_ready : direct_take);
	assign in_ready    = !link_down && (!a_valid_q || a_fire);
	assign in_take     = in_valid && in_ready && !a_strip_end;

	always_comb begin
		a_out     = a_q;
		a_out.eof = a_q.eof || a_strip_end;
	end

	assign hold.push_valid = a_emit && route_hold;
	assign hold.push_word  = a_out;
	assign hold.flush      = link_down;

	always_comb begin
		a_d         = a_q;
		a_valid_d   = a_valid_q && !a_fire;
		pkt_pois_d  = pkt_pois_q;
		pkt_np_d    = pkt_np_q;
		pkt_strip_d = pkt_strip_q;
		route_d     = (a_fire && a_q.sof) ? route_hold : route_q;
		if (in_valid && in_sof) begin
			pkt_pois_d  = in_dw[trsp_pkg::HDR_EP];
			pkt_np_d    = trsp_is_np(in_dw);
			pkt_strip_d = strip_digest_option && in_dw[trsp_pkg::HDR_TD];
		end
		if (in_take) begin
			a_valid_d = 1'b1;
			a_d.sof   = in_sof;
			a_d.eof   = in_eof;
			a_d.dw    = in_dw;
			a_d.poison = pkt_pois_d;
			a_d.np    = pkt_np_d;
			a_d.strip = pkt_strip_d;
			if (in_sof && pkt_strip_d) begin
				a_d.dw[trsp_pkg::HDR_TD] = 1'b0;
			end
		end
		if (link_down) begin
			a_valid_d = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			a_q         <= '0;
			a_valid_q   <= 1'b0;
			pkt_pois_q  <= 1'b0;
			pkt_np_q    <= 1'b0;
			pkt_strip_q <= 1'b0;
			route_q     <= 1'b0;
		end else begin
			a_q         <= a_d;
			a_valid_q   <= a_valid_d;
			pkt_pois_q  <= pkt_pois_d;
			pkt_np_q    <= pkt_np_d;
			pkt_strip_q <= pkt_strip_d;
			route_q     <= route_d;
		end
	end

	// ----------------------------------------------------------------
	// Beat packer and user handshake
	// ----------------------------------------------------------------
	trsp_pack_t           state_q, state_d;
	logic [127:0]         beat_q, beat_d;
	logic [1:0]           slot_q, slot_d;
	logic [1:0]           rem_q, rem_d;
	logic                 sof_q, sof_d, eof_q, eof_d, pois_q, pois_d;
	logic                 mid_q, mid_d, src_q, src_d, late_q, late_d;
	logic                 user_mid_q, user_mid_d, strad_q, strad_d;
	logic                 down_q, abort_q, abort_d;
	logic                 src_sel, src_valid, take, accept;
	trsp_pkg::trsp_word_t src_w;

	assign src_sel     = mid_q ? src_q : (!rx_np_ok_n && hold.has_pkt);
	assign src_valid   = src_sel ? hold.pop_valid : (a_emit && !route_hold);
	assign src_w       = src_sel ? hold.pop_word : a_out;
	// no refill while a beat is shown; a straddle slot takes only a packet start
	assign take        = !link_down && src_valid && (state_q == P_FILL || (state_q == P_STRAD && src_w.sof));
	assign direct_take = take && !src_sel;
	assign hold.pop_ready = take && src_sel;
	assign accept      = state_q == P_SHOW && !rx_ready_n;

	always_comb begin
		state_d    = state_q;
		beat_d     = beat_q;
		slot_d     = slot_q;
		rem_d      = rem_q;
		sof_d      = sof_q;
		eof_d      = eof_q;
		pois_d     = pois_q;
		mid_d      = mid_q;
		src_d      = src_q;
		late_d     = late_q;
		strad_d    = strad_q;
		user_mid_d = user_mid_q;
		case (state_q)
			P_FILL: begin
				if (take) begin
					slot_d = slot_q;
					if (src_w.sof && slot_q == trsp_pkg::SLOT_FIRST && late_q) begin
						slot_d = trsp_pkg::SLOT_LOWER;
						rem_d  = trsp_pkg::REM_LOW_ONLY;
					end
					late_d = 1'b0;
					beat_d[{~slot_d, 5'h00} +: 32] = src_w.dw;
					sof_d  = sof_q || src_w.sof;
					pois_d = pois_q || src_w.poison;
					src_d  = src_sel;
					mid_d  = !src_w.eof;
					if (src_w.eof) begin
						eof_d = 1'b1;
						rem_d = 2'(trsp_pkg::SLOT_LAST - slot_d);
						state_d = slot_d[1] ? P_SHOW : P_STRAD;
						slot_d  = trsp_pkg::SLOT_LOWER;
					end else if (slot_d == trsp_pkg::SLOT_LAST) begin
						state_d = P_SHOW;
					end else begin
						slot_d = 2'(slot_d + 2'h1);
					end
				end
			end
			P_STRAD: begin
				if (take) begin
					beat_d[{~trsp_pkg::SLOT_LOWER, 5'h00} +: 32] = src_w.dw;
					sof_d   = 1'b1;
					strad_d = 1'b1;
					pois_d  = pois_q || src_w.poison;
					mid_d   = 1'b1;
					src_d   = src_sel;
					slot_d  = trsp_pkg::SLOT_LAST;
					state_d = P_FILL;
				end else begin
					late_d  = 1'b1;
					state_d = P_SHOW;
				end
			end
			P_SHOW: begin
				if (accept) begin
					state_d    = P_FILL;
					slot_d     = trsp_pkg::SLOT_FIRST;
					rem_d      = trsp_pkg::REM_FULL;
					sof_d      = 1'b0;
					eof_d      = 1'b0;
					pois_d     = 1'b0;
					strad_d    = 1'b0;
					user_mid_d = sof_q ? (!eof_q || strad_q) : (user_mid_q && !eof_q);
				end
			end
			default: begin
				state_d = P_FILL;
			end
		endcase
		abort_d = link_down && !down_q && (user_mid_q || mid_q || state_q != P_FILL || a_valid_q);
		if (link_down) begin
			state_d    = P_FILL;
			slot_d     = trsp_pkg::SLOT_FIRST;
			rem_d      = trsp_pkg::REM_FULL;
			sof_d      = 1'b0;
			eof_d      = 1'b0;
			pois_d     = 1'b0;
			mid_d      = 1'b0;
			late_d     = 1'b0;
			strad_d    = 1'b0;
			user_mid_d = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_q    <= P_FILL;
			beat_q     <= '0;
			slot_q     <= trsp_pkg::SLOT_FIRST;
			rem_q      <= trsp_pkg::REM_FULL;
			sof_q      <= 1'b0;
			eof_q      <= 1'b0;
			pois_q     <= 1'b0;
			mid_q      <= 1'b0;
			src_q      <= 1'b0;
			late_q     <= 1'b0;
			strad_q    <= 1'b0;
			user_mid_q <= 1'b0;
			down_q     <= 1'b0;
			abort_q    <= 1'b0;
		end else begin
			state_q    <= state_d;
			beat_q     <= beat_d;
			slot_q     <= slot_d;
			rem_q      <= rem_d;
			sof_q      <= sof_d;
			eof_q      <= eof_d;
			pois_q     <= pois_d;
			mid_q      <= mid_d;
			src_q      <= src_d;
			late_q     <= late_d;
			strad_q    <= strad_d;
			user_mid_q <= user_mid_d;
			down_q     <= link_down;
			abort_q    <= abort_d;
		end
	end

	// valid only on a built beat
	assign rx_valid_n  = state_q != P_SHOW;
	assign rx_data     = beat_q;
	assign rx_sof_n    = !sof_q;
	assign rx_eof_n    = !eof_q;
	assign rx_rem_n    = rem_q;
	assign rx_errfwd_n = !pois_q;
	assign rx_abort_n  = !abort_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	a_stall_freeze: assert property (!rx_valid_n && rx_ready_n && !link_up_n |=>
		!rx_valid_n && $stable(rx_data) && $stable(rx_sof_n) && $stable(rx_rem_n)) else $error("beat moved while stalled");
	a_first_beat_sof: assert property (!rx_valid_n && !user_mid_q |-> !rx_sof_n)
		else $error("new packet beat without start");
	a_mid_no_sof: assert property (!rx_valid_n && user_mid_q && rx_eof_n |-> rx_sof_n)
		else $error("start inside a packet");
	a_rem_low_end: assert property (!rx_valid_n && !rx_sof_n && !rx_eof_n && strad_q |-> rx_rem_n[1])
		else $error("straddle without upper end");
	a_link_abort: assert property ($rose(link_up_n) && (user_mid_q || !rx_valid_n) |=>
		!rx_abort_n ##1 rx_abort_n) else $error("abort not pulsed on link loss");
	a_down_quiet: assert property (link_up_n |=> rx_valid_n)
		else $error("beat shown while link down");
	a_np_only_parked: assert property (hold.push_valid |-> a_q.np)
		else $error("non-np packet parked");
	a_np_first: assert property (!mid_q && !rx_np_ok_n && hold.has_pkt && take |-> src_sel)
		else $error("held np packet bypassed");
	a_poison_carry: assert property (in_take && in_sof && in_dw[trsp_pkg::HDR_EP] |=> a_q.poison)
		else $error("poison not captured");
	a_strip_td: assert property (in_take && in_sof && strip_digest_option && in_dw[trsp_pkg::HDR_TD]
		|=> !a_q.dw[trsp_pkg::HDR_TD]) else $error("digest bit not cleared");
	a_keep_td: assert property (in_take && in_sof && !strip_digest_option |=> a_q.dw == $past(in_dw))
		else $error("header altered without strip");

	c_straddle: cover property (!rx_valid_n && !rx_sof_n && !rx_eof_n && strad_q && !rx_ready_n);
	c_stall: cover property (!rx_valid_n && rx_ready_n ##1 !rx_valid_n && !rx_ready_n);
	c_np_park: cover property (hold.push_valid && hold.push_ready ##[1:50] hold.pop_ready);
	c_abort: cover property (!rx_abort_n);
endmodule
`default_nettype wire

//--- verif/trsp_user_model.sv
// Behavioural user logic that takes receive beats and unpacks them into dwords.
`timescale 1ns/100ps
`default_nettype none
module trsp_user_model (
	input  wire logic         clock,
	input  wire logic         srst,
	input  wire logic [1:0]   stall_mode,
	input  wire logic [127:0] rx_data,
	input  wire logic         rx_valid_n,
	input  wire logic         rx_sof_n,
	input  wire logic         rx_eof_n,
	input  wire logic [1:0]   rx_rem_n,
	input  wire logic         rx_errfwd_n,
	output logic              rx_ready_n
);
	logic [31:0] dws[$];
	logic        pzs[$];
	int          n_end = 0;
	int          n_sof = 0;
	logic [1:0]  cnt_q;

	// ----------------------------------------------------------------
	// Readiness
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_q <= 2'h0;
		end else begin
			cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
		end
	end

	// active low ready
	// Mode 0 is always ready, mode 1 one cycle in three, mode 2 never.
	assign rx_ready_n = srst || stall_mode == 2'h2 || (stall_mode == 2'h1 && cnt_q != 2'h0);

	// ----------------------------------------------------------------
	// Beat capture
	// ----------------------------------------------------------------
	// accepted beats only
	// A straddled beat closes one packet in the upper half and opens the next in the lower half.
	always @(posedge clock) begin
		int   e;
		int   s0;
		logic sof;
		logic eof;
		if (!srst && !rx_valid_n && !rx_ready_n) begin
			sof = !rx_sof_n;
			eof = !rx_eof_n;
			e = 3 - int'(rx_rem_n);
			s0 = (sof && !eof && rx_rem_n == 2'h2) ? 2 : 0;
			if (sof)
				n_sof++;
			for (int s = s0; s < 4; s++) begin
				if (!(eof && s > e && !(sof && rx_rem_n[1] && s >= 2))) begin
					dws.push_back(rx_data[127 - 32 * s -: 32]);
					pzs.push_back(!rx_errfwd_n);
					if (eof && s == e)
						n_end++;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- verif/tb_tlp_receive_stream_port.sv
// Self-checking testbench for the receive stream port.
`timescale 1ns/100ps
`default_nettype none
module tb_tlp_receive_stream_port;
	logic         clock = 1'b0;
	logic         srst;
	logic         in_valid;
	logic         in_ready;
	logic [31:0]  in_dw;
	logic         in_sof;
	logic         in_eof;
	logic         strip;
	logic         link_up_n;
	logic         rx_ready_n;
	logic         rx_np_ok_n;
	logic [127:0] rx_data;
	logic         rx_valid_n;
	logic         rx_sof_n;
	logic         rx_eof_n;
	logic [1:0]   rx_rem_n;
	logic         rx_errfwd_n;
	logic         rx_abort_n;
	logic [1:0]   stall_mode;
	logic [31:0]  exp_dw[$];
	logic         exp_pz[$];
	logic [31:0]  park_dw[$];
	logic         park = 1'b0;
	int           exp_end = 0;
	int           num_errors = 0;
	int           checks = 0;

	always #10 clock = ~clock;

	trsp_rx_port i_dut (
		.clock(clock), .srst(srst), .in_valid(in_valid), .in_ready(in_ready), .in_dw(in_dw),
		.in_sof(in_sof), .in_eof(in_eof), .strip_digest_option(strip), .link_up_n(link_up_n),
		.rx_ready_n(rx_ready_n), .rx_np_ok_n(rx_np_ok_n), .rx_data(rx_data), .rx_valid_n(rx_valid_n),
		.rx_sof_n(rx_sof_n), .rx_eof_n(rx_eof_n), .rx_rem_n(rx_rem_n), .rx_errfwd_n(rx_errfwd_n),
		.rx_abort_n(rx_abort_n)
	);

	trsp_user_model i_user (
		.clock(clock), .srst(srst), .stall_mode(stall_mode), .rx_data(rx_data), .rx_valid_n(rx_valid_n),
		.rx_sof_n(rx_sof_n), .rx_eof_n(rx_eof_n), .rx_rem_n(rx_rem_n), .rx_errfwd_n(rx_errfwd_n),
		.rx_ready_n(rx_ready_n)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic fail_wait();
		num_errors++;
		$display("unexpected wait: bound reached");
		stop_test();
	endtask

	task automatic send_dw(input logic [31:0] d, input logic s, input logic e);
		int n;
		n = 0;
		in_valid <= 1'b1;
		in_dw <= d;
		in_sof <= s;
		in_eof <= e;
		@(negedge clock);
		while (in_ready !== 1'b1 && n < 300) begin
			n++;
			@(negedge clock);
		end
		if (n >= 300)
			fail_wait();
		@(posedge clock);
	endtask

	// Header dword carries format, type, digest and poison bits; the id marks each packet.
	task automatic send_pkt(input logic [7:0] id, input logic [4:0] ty, input logic dat, input logic td,
			input logic ep, input int len);
		logic [31:0] d;
		for (int i = 0; i < len; i++) begin
			d = (i == 0) ? {1'b0, dat, 1'b0, ty, 8'h00, td, ep, 6'h00, id} : {id, 8'h5a, 16'(i)};
			if (!(strip && td && i == len - 1)) begin
				if (park)
					park_dw.push_back((strip && i == 0) ? d & 32'hffff7fff : d);
				else begin
					exp_dw.push_back((strip && i == 0) ? d & 32'hffff7fff : d);
					exp_pz.push_back(ep);
				end
			end
			send_dw(d, i == 0, i == len - 1);
		end
		if (!park)
			exp_end++;
	endtask

	task automatic idle();
		in_valid <= 1'b0;
		@(posedge clock);
	endtask

	task automatic drain();
		int n;
		n = 0;
		while (i_user.dws.size() < exp_dw.size() && n < 600) begin
			n++;
			@(posedge clock);
		end
		if (n >= 600)
			fail_wait();
		check("dword count", i_user.dws.size(), exp_dw.size());
		check("packet ends", i_user.n_end, exp_end);
		check("packet starts", i_user.n_sof, exp_end);
		for (int i = 0; i < exp_dw.size(); i++) begin
			check("dword", i_user.dws[i], exp_dw[i]);
			check("poison flag", i_user.pzs[i], exp_pz[i]);
		end
		exp_dw.delete();
		exp_pz.delete();
		i_user.dws.delete();
		i_user.pzs.delete();
		i_user.n_end = 0;
		i_user.n_sof = 0;
		exp_end = 0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_single();
		for (int k = 0; k < 3; k++) begin
			send_pkt(8'(k + 1), trsp_pkg::TYPE_MEM, k == 2, 1'b0, 1'b0, (k == 0) ? 3 : 4);
			idle();
			drain();
		end
		$display("test single done");
	endtask

	task automatic t_stall();
		stall_mode <= 2'h2;
		send_pkt(8'h10, trsp_pkg::TYPE_MEM, 1'b1, 1'b0, 1'b0, 5);
		idle();
		repeat (6) @(posedge clock);
		check("valid while stalled", rx_valid_n, 1'b0);
		check("start while stalled", rx_sof_n, 1'b0);
		check("beats while stalled", i_user.dws.size(), 0);
		stall_mode <= 2'h1;
		for (int k = 5; k < 9; k++)
			send_pkt(8'(k + 6), trsp_pkg::TYPE_MEM, 1'b1, 1'b0, 1'b0, k);
		idle();
		drain();
		stall_mode <= 2'h0;
		$display("test stall done");
	endtask

	task automatic t_poison();
		send_pkt(8'h20, trsp_pkg::TYPE_MEM, 1'b1, 1'b0, 1'b1, 6);
		idle();
		drain();
		send_pkt(8'h21, trsp_pkg::TYPE_MEM, 1'b1, 1'b0, 1'b0, 5);
		idle();
		drain();
		$display("test poison done");
	endtask

	task automatic t_digest();
		strip <= 1'b1;
		@(posedge clock);
		send_pkt(8'h30, trsp_pkg::TYPE_MEM, 1'b1, 1'b1, 1'b0, 6);
		idle();
		drain();
		strip <= 1'b0;
		@(posedge clock);
		send_pkt(8'h31, trsp_pkg::TYPE_MEM, 1'b1, 1'b1, 1'b0, 6);
		idle();
		drain();
		$display("test digest done");
	endtask

	task automatic t_np();
		rx_np_ok_n <= 1'b1;
		park = 1'b1;
		send_pkt(8'h40, trsp_pkg::TYPE_IO, 1'b0, 1'b0, 1'b0, 3);
		send_pkt(8'h41, trsp_pkg::TYPE_CFG0, 1'b0, 1'b0, 1'b0, 3);
		park = 1'b0;
		send_pkt(8'h42, trsp_pkg::TYPE_MEM, 1'b1, 1'b0, 1'b0, 5);
		send_pkt(8'h43, 5'h0a, 1'b1, 1'b0, 1'b0, 4);
		idle();
		drain();
		foreach (park_dw[i]) begin
			exp_dw.push_back(park_dw[i]);
			exp_pz.push_back(1'b0);
		end
		park_dw.delete();
		exp_end = 2;
		rx_np_ok_n <= 1'b0;
		// A posted write arriving behind the parked requests must wait until they are out.
		send_pkt(8'h44, trsp_pkg::TYPE_MEM, 1'b1, 1'b0, 1'b0, 4);
		idle();
		drain();
		$display("test non-posted done");
	endtask

	task automatic t_link();
		stall_mode <= 2'h2;
		send_pkt(8'h50, trsp_pkg::TYPE_MEM, 1'b1, 1'b0, 1'b0, 5);
		idle();
		repeat (4) @(posedge clock);
		link_up_n <= 1'b1;
		@(posedge clock);
		@(negedge clock);
		check("abort pulse", rx_abort_n, 1'b0);
		check("valid after abort", rx_valid_n, 1'b1);
		@(negedge clock);
		check("abort end", rx_abort_n, 1'b1);
		@(posedge clock);
		link_up_n <= 1'b0;
		stall_mode <= 2'h0;
		exp_dw.delete();
		exp_pz.delete();
		exp_end = 0;
		repeat (20) @(posedge clock);
		drain();
		$display("test link down done");
	endtask

	initial begin
		srst = 1'b1;
		in_valid = 1'b0;
		in_dw = 32'h0;
		in_sof = 1'b0;
		in_eof = 1'b0;
		strip = 1'b0;
		link_up_n = 1'b0;
		rx_np_ok_n = 1'b0;
		stall_mode = 2'h0;
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		t_single();
		t_stall();
		t_poison();
		t_digest();
		t_np();
		t_link();
		stop_test();
	end
endmodule
`default_nettype wire
